// ===== rtl/aci_params.svh
// Bit positions, reset values and widths of the feature control slice
`ifndef ACI_PARAMS_SVH
`define ACI_PARAMS_SVH

`define ACI_REG_WIDTH        32
`define ACI_SLICE_HI         17
`define ACI_SLICE_LO         8
`define ACI_SLICE_WIDTH      10
`define ACI_SLICE_RESET      10'h000

`define ACI_BIT_WAIT_IDLE    17
`define ACI_BIT_FORCE_FLUSH  16
`define ACI_BIT_FORCE_TRACE  15
`define ACI_BIT_FORCE_SIMD   14
`define ACI_BIT_FORCE_MAIN   13
`define ACI_BIT_SINGLE_SIMD  12
`define ACI_BIT_SINGLE_LDST  11
`define ACI_BIT_SINGLE_ALL   10
`define ACI_BIT_PLD_NOP      9
`define ACI_BIT_WFI_NOP      8

`define ACI_RDATA_RESET      32'h0000_0000
`define ACI_SYNC_RESET       3'h0

`endif

// ===== rtl/aci_pkg.sv
// Types shared by the feature control slice and its sleep sequencer
package aci_pkg;

   // Low-power sequencer states
   typedef enum logic [1:0] {
      ACI_RUN   = 2'b00,
      ACI_DRAIN = 2'b01,
      ACI_SLEEP = 2'b10
   } aci_sleep_state_t;

   // Sequencer state
   typedef struct packed {
      aci_sleep_state_t state;
      logic [2:0]       irq_sync;
      logic [2:0]       dbg_sync;
      logic             irq_level;
      logic             dbg_level;
      logic             sleep;
      logic             wake;
   } aci_seq_t;

   // Control slice state
   typedef struct packed {
      logic [9:0]  slice;
      logic [31:0] rdata;
      logic        done;
      logic        undef;
      logic        stall;
      logic        flush;
      logic        trace_en;
      logic        simd_en;
      logic        main_en;
      logic        dual_ok;
      logic        pld_req;
      logic        pld_retire;
      logic        wfi_retire;
   } aci_core_t;

endpackage

// ===== rtl/aci_sleep_seq.sv
// Wait-for-interrupt low-power sequencer with wake-up synchronisers
`timescale 1ns/1ps
`include "aci_params.svh"

module aci_sleep_seq
   import aci_pkg::*;
(
   input  wire logic mclk_in,
   input  wire logic resetn_in,
   input  wire logic wfi_enter_in,
   input  wire logic mem_outstanding_in,
   input  wire logic irq_in,
   input  wire logic debug_req_in,
   output logic      sleep_out,
   output logic      wake_out
);

   aci_seq_t r;
   aci_seq_t next_r;

   // Sequencing: drain memory, sleep, wake on interrupt or debug request
   always_comb begin
      next_r          = r;
      next_r.wake     = 1'b0;
      // Three-stage synchronisers; stage one feeds stage two only
      next_r.irq_sync = {r.irq_sync[1:0], irq_in};
      next_r.dbg_sync = {r.dbg_sync[1:0], debug_req_in};
      // A level counts only once stages two and three agree
      if (r.irq_sync[1] == r.irq_sync[2]) begin
         next_r.irq_level = r.irq_sync[2];
      end
      if (r.dbg_sync[1] == r.dbg_sync[2]) begin
         next_r.dbg_level = r.dbg_sync[2];
      end
      case (r.state)
         ACI_RUN: begin
            if (wfi_enter_in) begin
               next_r.state = ACI_DRAIN;
            end
         end
         ACI_DRAIN: begin
            // Sleeping with accesses in flight would strand their answers
            if (r.irq_level || r.dbg_level) begin
               next_r.state = ACI_RUN;
               next_r.wake  = 1'b1;
            end else if (!mem_outstanding_in) begin
               next_r.state = ACI_SLEEP;
               next_r.sleep = 1'b1;
            end
         end
         ACI_SLEEP: begin
            if (r.irq_level || r.dbg_level) begin
               next_r.state = ACI_RUN;
               next_r.sleep = 1'b0;
               next_r.wake  = 1'b1;
            end
         end
         default: begin
            next_r.state = ACI_RUN;
            next_r.sleep = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r <= '{state: ACI_RUN, irq_sync: `ACI_SYNC_RESET, dbg_sync: `ACI_SYNC_RESET,
                irq_level: 1'b0, dbg_level: 1'b0, sleep: 1'b0, wake: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign sleep_out = r.sleep;
   assign wake_out  = r.wake;

endmodule // aci_sleep_seq

// ===== rtl/aci_core.sv
// Feature control slice: issue, clock, flush and hint overrides
// Operation
// - Wait-idle bit set: non-waiting serialized coprocessor ops stall until memory idle.
// - Forced-flush bit set: flush after every coprocessor op lacking native flush.
// - Trace-clock force bit set: trace unit clock enable stays asserted.
// - SIMD-clock force bit set: SIMD unit clock enable stays asserted.
// - Main-clock force bit set: main core clock enable stays asserted.
// - SIMD single-issue bit set: never pair a SIMD instruction with another.
// - Load/store single-issue bit set: every load or store issues alone.
// - Global single-issue bit set: at most one instruction issues per cycle, never a pair.
// - Preload no-op bit set: preload hints retire with no memory access.
// - Preload no-op bit clear: each preload hint performs a memory access.
// - Wait-for-interrupt no-op bit set: instruction retires, no low-power state.
// - No-op bit clear: wait-for-interrupt sleeps until interrupt or debug request.
// - Only privileged modes reach the register; user access raises undefined.
`timescale 1ns/1ps
`include "aci_params.svh"

module aci_core
   import aci_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   // Coprocessor register access
   input  wire logic        reg_access_in,
   input  wire logic        reg_write_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_privileged_in,
   input  wire logic        reg_secure_in,
   output logic [31:0]      reg_rdata_out,
   output logic             reg_done_out,
   output logic             reg_undef_out,
   // Serialized coprocessor instructions
   input  wire logic        sysop_valid_in,
   input  wire logic        sysop_native_wait_in,
   input  wire logic        sysop_retire_in,
   input  wire logic        sysop_native_flush_in,
   input  wire logic        mem_outstanding_in,
   output logic             sysop_stall_out,
   output logic             pipeline_flush_out,
   // Clock enable requests from the clock generator
   input  wire logic        trace_clk_req_in,
   input  wire logic        simd_clk_req_in,
   input  wire logic        main_clk_req_in,
   output logic             trace_clk_en_out,
   output logic             simd_clk_en_out,
   output logic             main_clk_en_out,
   // Dual issue candidates
   input  wire logic        pair_ok_in,
   input  wire logic        slot0_simd_in,
   input  wire logic        slot0_ldst_in,
   input  wire logic        slot1_simd_in,
   input  wire logic        slot1_ldst_in,
   output logic             dual_issue_out,
   // Preload hint
   input  wire logic        preload_hint_in,
   output logic             preload_mem_req_out,
   output logic             preload_retire_out,
   // Wait for interrupt
   input  wire logic        wait_for_interrupt_in,
   input  wire logic        irq_in,
   input  wire logic        debug_req_in,
   output logic             wfi_retire_out,
   output logic             core_sleep_out,
   output logic             core_wake_out
);

   aci_core_t r;
   aci_core_t next_r;
   logic      wfi_enter;
   logic      seq_sleep;
   logic      seq_wake;

   // Reads one control bit by its register bit number
   function automatic logic ctl(input logic [9:0] slice, input int pos);
      ctl = slice[pos - `ACI_SLICE_LO];
   endfunction

   // True when either issue slot holds an instruction of the class
   function automatic logic either(input logic a, input logic b);
      either = a | b;
   endfunction

   // Sleep request only when the no-op override is clear
   assign wfi_enter = wait_for_interrupt_in && !ctl(r.slice, `ACI_BIT_WFI_NOP);

   // Low-power sequencer
   aci_sleep_seq u_sleep (
      .mclk_in            (mclk_in),
      .resetn_in          (resetn_in),
      .wfi_enter_in       (wfi_enter),
      .mem_outstanding_in (mem_outstanding_in),
      .irq_in             (irq_in),
      .debug_req_in       (debug_req_in),
      .sleep_out          (seq_sleep),
      .wake_out           (seq_wake)
   );

   // Next-state logic for registers and every override output
   always_comb begin
      next_r       = r;
      next_r.done  = 1'b0;
      next_r.undef = 1'b0;

      // Register access; answer one cycle after the request
      if (reg_access_in) begin
         if (!reg_privileged_in) begin
            next_r.undef = 1'b1;
         end else begin
            next_r.done = 1'b1;
            if (reg_write_in) begin
               // Nonsecure writes complete but leave the slice unchanged
               if (reg_secure_in) begin
                  next_r.slice = reg_wdata_in[`ACI_SLICE_HI:`ACI_SLICE_LO];
               end
            end else begin
               // Bits outside this slice belong to other logic, read zero here
               next_r.rdata = `ACI_RDATA_RESET;
               next_r.rdata[`ACI_SLICE_HI:`ACI_SLICE_LO] = r.slice;
            end
         end
      end

      // Stall serialized ops while memory is busy, native or forced
      next_r.stall = sysop_valid_in && mem_outstanding_in &&
                     (sysop_native_wait_in || ctl(r.slice, `ACI_BIT_WAIT_IDLE));

      // Flush after retiring ops, native or forced
      next_r.flush = sysop_retire_in &&
                     (sysop_native_flush_in || ctl(r.slice, `ACI_BIT_FORCE_FLUSH));

      // Clock enables; a force bit overrides any gating decision
      next_r.trace_en = trace_clk_req_in || ctl(r.slice, `ACI_BIT_FORCE_TRACE);
      next_r.simd_en  = simd_clk_req_in  || ctl(r.slice, `ACI_BIT_FORCE_SIMD);
      // Main clock also stops in sleep unless forced
      next_r.main_en  = (main_clk_req_in && !seq_sleep) ||
                        ctl(r.slice, `ACI_BIT_FORCE_MAIN);

      // Pairing permission; each override can only veto
      next_r.dual_ok = pair_ok_in;
      if (ctl(r.slice, `ACI_BIT_SINGLE_SIMD) && either(slot0_simd_in, slot1_simd_in)) begin
         next_r.dual_ok = 1'b0;
      end
      if (ctl(r.slice, `ACI_BIT_SINGLE_LDST) && either(slot0_ldst_in, slot1_ldst_in)) begin
         next_r.dual_ok = 1'b0;
      end
      if (ctl(r.slice, `ACI_BIT_SINGLE_ALL)) begin
         next_r.dual_ok = 1'b0;
      end

      // Preload hints: memory access or silent retire
      next_r.pld_req    = preload_hint_in && !ctl(r.slice, `ACI_BIT_PLD_NOP);
      next_r.pld_retire = preload_hint_in && ctl(r.slice, `ACI_BIT_PLD_NOP);

      // Wait for interrupt retires at once when overridden
      next_r.wfi_retire = wait_for_interrupt_in && ctl(r.slice, `ACI_BIT_WFI_NOP);
   end

   // State register; every control bit resets to zero
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r <= '{slice: `ACI_SLICE_RESET, rdata: `ACI_RDATA_RESET, done: 1'b0,
                undef: 1'b0, stall: 1'b0, flush: 1'b0, trace_en: 1'b0,
                simd_en: 1'b0, main_en: 1'b0, dual_ok: 1'b0, pld_req: 1'b0,
                pld_retire: 1'b0, wfi_retire: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // Outputs, all from flip-flops
   assign reg_rdata_out       = r.rdata;
   assign reg_done_out        = r.done;
   assign reg_undef_out       = r.undef;
   assign sysop_stall_out     = r.stall;
   assign pipeline_flush_out  = r.flush;
   assign trace_clk_en_out    = r.trace_en;
   assign simd_clk_en_out     = r.simd_en;
   assign main_clk_en_out     = r.main_en;
   assign dual_issue_out      = r.dual_ok;
   assign preload_mem_req_out = r.pld_req;
   assign preload_retire_out  = r.pld_retire;
   assign wfi_retire_out      = r.wfi_retire;
   assign core_sleep_out      = seq_sleep;
   assign core_wake_out       = seq_wake;

endmodule // aci_core

// ===== verif/aci_core_props.sv
// Port-level checker for the feature control slice
`timescale 1ns/1ps
module aci_core_props (
   input wire logic        mclk_in, resetn_in, reg_access_in, reg_write_in, reg_done_out,
   input wire logic        reg_privileged_in, reg_secure_in, reg_undef_out, sysop_valid_in,
   input wire logic        sysop_native_wait_in, sysop_retire_in, mem_outstanding_in,
   input wire logic        sysop_stall_out, pipeline_flush_out, trace_clk_req_in,
   input wire logic        trace_clk_en_out, main_clk_en_out, pair_ok_in, dual_issue_out,
   input wire logic        preload_hint_in, preload_mem_req_out, preload_retire_out,
   input wire logic        core_sleep_out, core_wake_out,
   input wire logic [31:0] reg_wdata_in, reg_rdata_out
);
   // Shadow of the slice, since only the ports are visible here
   logic [9:0] slc;
   always_ff @(posedge mclk_in or negedge resetn_in)
      if (!resetn_in) slc <= 10'h000;
      else if (reg_access_in && reg_write_in && reg_privileged_in && reg_secure_in)
         slc <= reg_wdata_in[17:8];
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   a_user_undef: assert property (reg_access_in && !reg_privileged_in |=>
      reg_undef_out && !reg_done_out) else $error("user access not refused");
   a_priv_done: assert property (reg_access_in && reg_privileged_in |=>
      reg_done_out && !reg_undef_out) else $error("privileged access not done");
   a_read_slice: assert property (reg_access_in && !reg_write_in && reg_privileged_in |=>
      reg_rdata_out == {14'h0000, $past(slc), 8'h00}) else $error("read data wrong");
   a_stall_wait: assert property (sysop_valid_in && mem_outstanding_in &&
      (sysop_native_wait_in || slc[9]) |=> sysop_stall_out) else $error("no stall");
   a_flush_force: assert property (sysop_retire_in && slc[8] |=>
      pipeline_flush_out) else $error("no forced flush");
   a_trace_force: assert property (slc[7] || trace_clk_req_in |=>
      trace_clk_en_out) else $error("trace enable dropped");
   a_main_force: assert property (slc[5] |=> main_clk_en_out)
      else $error("main enable dropped");
   a_single_all: assert property (slc[2] || !pair_ok_in |=> !dual_issue_out)
      else $error("dual issue while single");
   a_pld_noop: assert property (preload_hint_in && slc[1] |=>
      preload_retire_out && !preload_mem_req_out) else $error("preload not a no-op");
   a_wake_pulse: assert property (core_wake_out |-> !core_sleep_out ##1 !core_wake_out)
      else $error("wake pulse wrong");
   // Main scenarios reached
   cover property (core_sleep_out ##1 !core_sleep_out);
   cover property (reg_undef_out);
   cover property (preload_retire_out);
endmodule // aci_core_props

bind aci_core aci_core_props aci_core_props_inst (.*);

// ===== verif/aci_core_tb.sv
// Self-checking bench for the feature control slice
`timescale 1ns/1ps
module aci_core_tb;
   logic mclk_in = 0, resetn_in = 0, reg_access_in = 0, reg_write_in = 0, reg_secure_in = 0;
   logic reg_privileged_in = 0, sysop_valid_in = 0, sysop_native_wait_in = 0, irq_in = 0;
   logic sysop_retire_in = 0, sysop_native_flush_in = 0, mem_outstanding_in = 0;
   logic trace_clk_req_in = 0, simd_clk_req_in = 0, main_clk_req_in = 0, pair_ok_in = 0;
   logic slot0_simd_in = 0, slot0_ldst_in = 0, slot1_simd_in = 0, slot1_ldst_in = 0;
   logic preload_hint_in = 0, wait_for_interrupt_in = 0, debug_req_in = 0;
   logic [31:0] reg_wdata_in = 0, reg_rdata_out;
   logic reg_done_out, reg_undef_out, sysop_stall_out, pipeline_flush_out, trace_clk_en_out;
   logic simd_clk_en_out, main_clk_en_out, dual_issue_out, preload_mem_req_out;
   logic preload_retire_out, wfi_retire_out, core_sleep_out, core_wake_out;
   logic [8:0] exp;
   int err_count = 0, check_count = 0, mdl = 0;
   aci_core aci_core_inst (.*);
   always #10 mclk_in = ~mclk_in;
   // Compare one result; four-state so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
      check_count++;
      if (got !== want) begin
         err_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask
   // One register access; the model applies the same access rules
   task automatic acc(input bit w, input bit p, input bit s, input logic [31:0] d);
      logic [31:0] rd;
      rd = {14'h0000, mdl[9:0], 8'h00};
      @(posedge mclk_in);
      {reg_access_in, reg_write_in, reg_privileged_in} <= {1'b1, w, p};
      // Drop a held wait request, so a write that clears the no-op bit cannot start a sleep
      {reg_secure_in, reg_wdata_in, wait_for_interrupt_in} <= {s, d, 1'b0};
      @(posedge mclk_in);
      reg_access_in <= 1'b0;
      if (w && p && s) mdl = d[17:8];
      #1;
      chk(reg_undef_out, !p, "undef");
      chk(reg_done_out, p, "done");
      if (!w && p) chk(reg_rdata_out, rd, "rdata");
   endtask
   // Random override inputs; WAIT_FOR_INTERRUPT only when it retires, so the core never sleeps here
   task automatic ovr();
      logic [16:0] r;
      logic [9:0] m;
      r = 17'($urandom);
      m = mdl[9:0];
      @(posedge mclk_in);
      {sysop_valid_in, sysop_native_wait_in, sysop_retire_in, sysop_native_flush_in,
       mem_outstanding_in, trace_clk_req_in, simd_clk_req_in, main_clk_req_in, pair_ok_in,
       slot0_simd_in, slot0_ldst_in, slot1_simd_in, slot1_ldst_in, preload_hint_in,
       irq_in, debug_req_in, wait_for_interrupt_in} <= {r[16:1], r[0] & m[0]};
      @(posedge mclk_in);
      exp = {sysop_valid_in & mem_outstanding_in & (sysop_native_wait_in | m[9]),
             sysop_retire_in & (sysop_native_flush_in | m[8]),
             trace_clk_req_in | m[7], simd_clk_req_in | m[6], main_clk_req_in | m[5],
             pair_ok_in & !(m[4] & (slot0_simd_in | slot1_simd_in))
                & !(m[3] & (slot0_ldst_in | slot1_ldst_in)) & !m[2],
             preload_hint_in & !m[1], preload_hint_in & m[1], wait_for_interrupt_in & m[0]};
      #1;
      chk({sysop_stall_out, pipeline_flush_out}, exp[8:7], "sysop");
      chk({trace_clk_en_out, simd_clk_en_out, main_clk_en_out}, exp[6:4], "clocks");
      chk(dual_issue_out, exp[3], "issue");
      chk({preload_mem_req_out, preload_retire_out, wfi_retire_out}, exp[2:0],
          "hints");
   endtask
   // Verdict and end of the run
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Watchdog, well beyond the expected run of about 760 cycles
   initial begin
      #100000;
      err_count++;
      test_done();
   end
   // Main sequence
   initial begin
      void'($urandom(22362));
      repeat (8) @(posedge mclk_in);
      resetn_in <= 1'b1;
      acc(0, 1, 0, 0);
      for (int i = 0; i < 40; i++) begin
         acc(1, 1, 1, $urandom);
         acc(1, 1, 0, $urandom);
         acc($urandom, 0, $urandom, $urandom);
         acc(0, 1, i[0], 0);
         repeat (5) ovr();
      end
      $display("Register and override test done");
      // Wait for interrupt with memory busy, drain, then sleep, then wake on an interrupt
      @(posedge mclk_in);
      {main_clk_req_in, mem_outstanding_in, irq_in, debug_req_in, wait_for_interrupt_in} <= 5'h18;
      acc(1, 1, 1, 0);
      repeat (3) @(posedge mclk_in);
      wait_for_interrupt_in <= 1'b1;
      @(posedge mclk_in);
      wait_for_interrupt_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      #1;
      chk(core_sleep_out, 0, "drain");
      @(posedge mclk_in);
      mem_outstanding_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      #1;
      chk(core_sleep_out, 1, "sleep");
      chk(main_clk_en_out, 0, "main gated");
      @(posedge mclk_in);
      irq_in <= 1'b1;
      for (int n = 0; n < 8 && core_wake_out !== 1'b1; n++) begin
         @(posedge mclk_in);
         #1;
      end
      chk(core_wake_out, 1, "wake");
      chk(core_sleep_out, 0, "awake");
      // No-op wait with the main enable forced
      acc(1, 1, 1, 32'h0000_2100);
      @(posedge mclk_in);
      {irq_in, main_clk_req_in, wait_for_interrupt_in} <= 3'h1;
      @(posedge mclk_in);
      wait_for_interrupt_in <= 1'b0;
      #1;
      chk(wfi_retire_out, 1, "wfi retire");
      repeat (3) @(posedge mclk_in);
      #1;
      chk(core_sleep_out, 0, "no sleep");
      chk(main_clk_en_out, 1, "main forced");
      $display("Sleep test done");
      test_done();
   end
endmodule // aci_core_tb
